// *** shared/idsp_pkg.sv ***
/*
 * Constants and carrier types for the identification, information and
 * scratchpad register bank.
 * Assumes a serial-port front end that has already decoded the command
 * code, page and data word of each transfer.
 */
package idsp_pkg;

    // ==========================================================
    // command codes
    // ==========================================================
    localparam logic [7:0] CMD_CAPABILITY = 8'h19;
    localparam logic [7:0] CMD_BUS_REV = 8'h98;
    localparam logic [7:0] CMD_TOOL_WORD_A = 8'hB0;
    localparam logic [7:0] CMD_TOOL_WORD_B_PG = 8'hB1;
    localparam logic [7:0] CMD_OEM_WORD = 8'hB2;
    localparam logic [7:0] CMD_SCRATCH_PG = 8'hB3;
    localparam logic [7:0] CMD_SCRATCH_UNPG = 8'hB4;
    localparam logic [7:0] CMD_MAKER_INFO = 8'hB6;
    localparam logic [7:0] CMD_MAKER_RSVD_PG = 8'hBC;
    localparam logic [7:0] CMD_MAKER_ID = 8'hE7;
    localparam logic [7:0] CMD_LOT_CODE = 8'hE8;

    // ==========================================================
    // capability summary fields
    // ==========================================================
    localparam int CAP_PEC_BIT = 7;
    localparam int CAP_SCL_LSB = 5;
    localparam int CAP_ALERT_BIT = 4;
    localparam logic [1:0] CAP_SCL_400K = 2'h1;
    localparam logic [3:0] CAP_RSVD = 4'h0;
    localparam logic [7:0] CAP_VALUE = {1'b1, CAP_SCL_400K, 1'b1, CAP_RSVD};

    // ==========================================================
    // information word fields
    // ==========================================================
    localparam int INFO_ECC_BIT = 5;
    localparam logic [15:0] INFO_RESET = 16'h0000;

    // ==========================================================
    // widths and reset values
    // ==========================================================
    localparam int WORD_W = 16;
    localparam int PAGE_W = 1;
    localparam int NUM_PAGES = 2;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] cmd;
        logic all_pages;
        logic [PAGE_W-1:0] page;
        logic [WORD_W-1:0] data;
    } idsp_req_s;

    typedef struct packed {
        logic valid;
        logic nack;
        logic [WORD_W-1:0] data;
    } idsp_rsp_s;

endpackage

// *** src/idsp_page_store.sv ***
/*
 * Per-page word storage, one word per page, flip-flop based.
 * Assumes writer and reader share sys_clk; read is combinational.
 */
`timescale 1ns/1ps
module idsp_page_store #(
    parameter int W = 16,
    parameter int PAGES = 2,
    parameter int PW = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic wr_all,
    input wire logic [PW-1:0] wr_page,
    input wire logic [W-1:0] wr_data,
    input wire logic [PW-1:0] rd_page,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem_r [PAGES];

    assign rd_data = mem_r[rd_page];

    // ==========================================================
    // storage
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < PAGES; i++) begin
            if (sys_rst) begin
                mem_r[i] <= '0;
            end else if (wr_en && (wr_all || wr_page == PW'(i))) begin
                mem_r[i] <= wr_data;
            end
        end
    end

endmodule // idsp_page_store

// *** src/idsp_regs.sv ***
/*
 * Identification, information and scratchpad register bank reached by
 * command code. Reads answer one cycle after the request.
 * Assumes the serial front end delivers at most one request per cycle and
 * the storage engine replays stored words over the load channel.
 */
// Notes on behaviour
// - capability read fixed, low nibble zero
// - capability bit 7 fixed one
// - checksum requirement reported here, as one in capability bit 7
// - capability bits 6:5 fixed at 01
// - capability bit 4 fixed one
// - revision read returns hard-wired code
// - identifier word always the same, unpaged
// - info word refreshed on reset, restore, bulk read
// - info bit 5 zero when corrections applied
// - tool words B0, B1 read/write, stored
// - words B3, B4 free user storage
`timescale 1ns/1ps
module idsp_regs #(
    parameter logic [15:0] MAKER_ID = 16'h5A5A, // arbitrary value
    parameter logic [7:0] BUS_REV = 8'h22 // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input idsp_pkg::idsp_req_s host_req,
    input idsp_pkg::idsp_req_s ee_load,
    input wire logic info_refresh,
    input wire logic ecc_clean,
    output idsp_pkg::idsp_rsp_s host_rsp
);
    import idsp_pkg::*;

    // ==========================================================
    // command decode
    // ==========================================================
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c == CMD_CAPABILITY) || (c == CMD_BUS_REV) ||
                    (c == CMD_MAKER_INFO) || (c == CMD_MAKER_ID) ||
                    (c == CMD_LOT_CODE) || cmd_writable(c);
    endfunction

    function automatic logic cmd_writable(input logic [7:0] c);
        cmd_writable = (c == CMD_TOOL_WORD_A) || (c == CMD_TOOL_WORD_B_PG) ||
                       (c == CMD_OEM_WORD) || (c == CMD_SCRATCH_PG) ||
                       (c == CMD_SCRATCH_UNPG) || (c == CMD_MAKER_RSVD_PG);
    endfunction

    // load channel wins over a host write in the same cycle
    wire logic ld_go = ee_load.wr;
    wire logic host_wr_ok = host_req.wr && cmd_writable(host_req.cmd);
    wire logic [7:0] wr_cmd = ld_go ? ee_load.cmd : host_req.cmd;
    wire logic [WORD_W-1:0] wr_data = ld_go ? ee_load.data : host_req.data;
    wire logic [PAGE_W-1:0] wr_page = ld_go ? ee_load.page : host_req.page;
    wire logic wr_all = ld_go ? ee_load.all_pages : host_req.all_pages;
    wire logic wr_go = ld_go || host_wr_ok;

    wire logic we_tool_a = wr_go && (wr_cmd == CMD_TOOL_WORD_A);
    wire logic we_tool_b = wr_go && (wr_cmd == CMD_TOOL_WORD_B_PG);
    wire logic we_oem = wr_go && (wr_cmd == CMD_OEM_WORD);
    wire logic we_scr_pg = wr_go && (wr_cmd == CMD_SCRATCH_PG);
    wire logic we_scr_unpg = wr_go && (wr_cmd == CMD_SCRATCH_UNPG);
    wire logic we_rsvd = wr_go && (wr_cmd == CMD_MAKER_RSVD_PG);
    // only the storage engine may set the lot code
    wire logic we_lot = ld_go && (ee_load.cmd == CMD_LOT_CODE);

    // ==========================================================
    // unpaged words
    // ==========================================================
    logic [WORD_W-1:0] tool_a_r;
    logic [WORD_W-1:0] oem_r;
    logic [WORD_W-1:0] scr_unpg_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tool_a_r <= WORD_RESET;
            oem_r <= WORD_RESET;
            scr_unpg_r <= WORD_RESET;
        end else begin
            if (we_tool_a) begin
                tool_a_r <= wr_data;
            end
            if (we_oem) begin
                oem_r <= wr_data;
            end
            if (we_scr_unpg) begin
                scr_unpg_r <= wr_data;
            end
        end
    end

    // ==========================================================
    // paged words
    // ==========================================================
    wire logic [WORD_W-1:0] tool_b_rd;
    wire logic [WORD_W-1:0] scr_pg_rd;
    wire logic [WORD_W-1:0] rsvd_rd;
    wire logic [WORD_W-1:0] lot_rd;

    idsp_page_store #(.W(WORD_W), .PAGES(NUM_PAGES), .PW(PAGE_W)) u_tool_b (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(we_tool_b),
        .wr_all(wr_all),
        .wr_page(wr_page),
        .wr_data(wr_data),
        .rd_page(host_req.page),
        .rd_data(tool_b_rd)
    );

    idsp_page_store #(.W(WORD_W), .PAGES(NUM_PAGES), .PW(PAGE_W)) u_scr_pg (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(we_scr_pg),
        .wr_all(wr_all),
        .wr_page(wr_page),
        .wr_data(wr_data),
        .rd_page(host_req.page),
        .rd_data(scr_pg_rd)
    );

    idsp_page_store #(.W(WORD_W), .PAGES(NUM_PAGES), .PW(PAGE_W)) u_rsvd (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(we_rsvd),
        .wr_all(wr_all),
        .wr_page(wr_page),
        .wr_data(wr_data),
        .rd_page(host_req.page),
        .rd_data(rsvd_rd)
    );

    idsp_page_store #(.W(WORD_W), .PAGES(NUM_PAGES), .PW(PAGE_W)) u_lot (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(we_lot),
        .wr_all(ee_load.all_pages),
        .wr_page(ee_load.page),
        .wr_data({8'h00, ee_load.data[7:0]}),
        .rd_page(host_req.page),
        .rd_data(lot_rd)
    );

    // ==========================================================
    // information word
    // ==========================================================
    logic [WORD_W-1:0] info_r;
    logic refresh_pend_r;

    // capture after reset release and on each refresh event
    wire logic info_take = refresh_pend_r || info_refresh;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            info_r <= INFO_RESET;
            refresh_pend_r <= 1'b1;
        end else begin
            refresh_pend_r <= 1'b0;
            // ecc status into bit 5 only
            if (info_take) begin
                info_r <= INFO_RESET | (WORD_W'(ecc_clean) << INFO_ECC_BIT);
            end
        end
    end

    // ==========================================================
    // read mux and answer
    // ==========================================================
    logic [WORD_W-1:0] rd_word;

    always_comb begin
        rd_word = WORD_RESET;
        unique case (host_req.cmd)
            // checksum requirement reflected as one in bit 7
            CMD_CAPABILITY: rd_word = {8'h00, CAP_VALUE};
            CMD_BUS_REV: rd_word = {8'h00, BUS_REV};
            CMD_TOOL_WORD_A: rd_word = tool_a_r;
            CMD_TOOL_WORD_B_PG: rd_word = tool_b_rd;
            CMD_OEM_WORD: rd_word = oem_r;
            CMD_SCRATCH_PG: rd_word = scr_pg_rd;
            CMD_SCRATCH_UNPG: rd_word = scr_unpg_r;
            CMD_MAKER_INFO: rd_word = info_r;
            CMD_MAKER_RSVD_PG: rd_word = rsvd_rd;
            CMD_MAKER_ID: rd_word = MAKER_ID;
            CMD_LOT_CODE: rd_word = lot_rd;
            default: rd_word = WORD_RESET;
        endcase
    end

    wire logic rd_ok = host_req.rd && cmd_known(host_req.cmd);
    wire logic bad_req = (host_req.rd && !cmd_known(host_req.cmd)) ||
                         (host_req.wr && !cmd_writable(host_req.cmd));

    idsp_rsp_s rsp_r;
    assign host_rsp = rsp_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= rd_ok;
            rsp_r.nack <= bad_req;
            if (rd_ok) begin
                rsp_r.data <= rd_word;
            end
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    AST_CAP_READ:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_req.rd && host_req.cmd == CMD_CAPABILITY
        |=> host_rsp.valid && host_rsp.data == 16'h00B0)
        else $error("capability read wrong");

    AST_CAP_PEC:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_rsp.valid && $past(host_req.cmd) == CMD_CAPABILITY
        |-> host_rsp.data[7])
        else $error("capability checksum bit not one");

    AST_CAP_SCL:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(rd_ok) && $past(host_req.cmd) == CMD_CAPABILITY
        |-> host_rsp.data[6:5] == 2'h1)
        else $error("capability bus rate field wrong");

    AST_CAP_ALERT:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_req.rd && host_req.cmd == CMD_CAPABILITY
        |-> ##1 host_rsp.data[4] && host_rsp.data[3:0] == 4'h0)
        else $error("capability alert bit wrong");

    AST_REV_READ:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_req.rd && host_req.cmd == CMD_BUS_REV
        |=> host_rsp.valid && host_rsp.data == {8'h00, BUS_REV})
        else $error("revision read wrong");

    AST_ID_READ:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_req.rd && host_req.cmd == CMD_MAKER_ID
        |=> host_rsp.data == MAKER_ID && !host_rsp.nack)
        else $error("identifier read wrong");

    AST_INFO_REFRESH:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        info_refresh |=> info_r[5] == $past(ecc_clean))
        else $error("info word not refreshed");

    AST_INFO_RSVD:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        info_r[15:6] == 10'h000 && info_r[4:0] == 5'h00)
        else $error("info reserved bits set");

    AST_SCRATCH_HOLD:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_req.wr && host_req.cmd == CMD_SCRATCH_UNPG && !ee_load.wr
        |=> scr_unpg_r == $past(host_req.data))
        else $error("scratch word lost write");

    AST_RO_REFUSED:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_req.wr && !cmd_writable(host_req.cmd)
        |=> host_rsp.nack && !host_rsp.valid)
        else $error("write to read-only not refused");

endmodule // idsp_regs

// *** dv/idsp_host_model.sv ***
/*
 * Host bus controller model: issues single read and write requests.
 * Assumes the bank answers on the taking edge itself; the model samples 1 ns later.
 */
`timescale 1ns/1ps
module idsp_host_model (
    input wire logic sys_clk,
    output idsp_pkg::idsp_req_s host_req,
    input idsp_pkg::idsp_rsp_s host_rsp
);
    import idsp_pkg::*;

    initial host_req = '0;

    // ==========================================================
    // one transfer
    // ==========================================================
    // host side: tool words only for checks, no checksum use
    task automatic xfer(input logic rd, input logic [7:0] cmd, input logic pg,
                        input logic all, input logic [15:0] d,
                        output logic v, output logic n, output logic [15:0] q);
        @(posedge sys_clk);
        host_req <= '{rd: rd, wr: ~rd, cmd: cmd, all_pages: all, page: pg, data: d};
        @(posedge sys_clk);
        host_req.rd <= 1'b0;
        host_req.wr <= 1'b0;
        host_req.data <= ~d;
        #1;
        v = host_rsp.valid;
        n = host_rsp.nack;
        q = host_rsp.data;
    endtask
endmodule // idsp_host_model

// *** dv/testbench.sv ***
/*
 * Self-checking bench for the identification and scratchpad bank.
 * Assumes the host model answers through its xfer task.
 */
`timescale 1ns/1ps
module testbench;
    import idsp_pkg::*;
    localparam logic [15:0] ID_VAL = 16'hC3A1; // arbitrary value
    localparam logic [7:0] REV_VAL = 8'h4E; // arbitrary value
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    idsp_req_s host_req;
    idsp_req_s ee_load = '0;
    logic info_refresh = 1'b0;
    logic ecc_clean = 1'b1;
    idsp_rsp_s host_rsp;
    int fails = 0;
    int n_compared = 0;
    logic [7:0] rw_codes [4] = '{8'hB0, 8'hB1, 8'hB2, 8'hBC};
    logic [7:0] ro_codes [5] = '{8'h19, 8'h98, 8'hB6, 8'hE7, 8'hE8};

    always #5 sys_clk = ~sys_clk;

    idsp_regs #(.MAKER_ID(ID_VAL), .BUS_REV(REV_VAL)) i_dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .host_req(host_req),
        .ee_load(ee_load),
        .info_refresh(info_refresh),
        .ecc_clean(ecc_clean),
        .host_rsp(host_rsp)
    );

    idsp_host_model i_host (
        .sys_clk(sys_clk),
        .host_req(host_req),
        .host_rsp(host_rsp)
    );

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic pg, input logic [15:0] exp);
        logic v, n;
        logic [15:0] q;
        i_host.xfer(1'b1, cmd, pg, 1'b0, 16'h0000, v, n, q);
        chk({15'h0000, v}, 16'h0001, "read valid");
        chk(q, exp, "read data");
    endtask

    task automatic wr_op(input logic [7:0] cmd, input logic pg, input logic all,
                         input logic [15:0] d, input logic exp_nack);
        logic v, n;
        logic [15:0] q;
        i_host.xfer(1'b0, cmd, pg, all, d, v, n, q);
        chk({15'h0000, n}, {15'h0000, exp_nack}, "write refusal");
    endtask

    task automatic ee_put(input logic [7:0] cmd, input logic pg, input logic [15:0] d);
        @(posedge sys_clk);
        ee_load <= '{rd: 1'b0, wr: 1'b1, cmd: cmd, all_pages: 1'b0, page: pg, data: d};
        @(posedge sys_clk);
        ee_load <= '0;
    endtask

    task automatic refresh(input logic clean);
        @(posedge sys_clk);
        ecc_clean <= clean;
        info_refresh <= 1'b1;
        @(posedge sys_clk);
        info_refresh <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic s_ident();
        logic v, n;
        logic [15:0] q;
        rd_chk(CMD_CAPABILITY, 1'b0, 16'h00B0);
        rd_chk(CMD_BUS_REV, 1'b1, {8'h00, REV_VAL});
        rd_chk(CMD_MAKER_ID, 1'b1, ID_VAL);
        for (int i = 0; i < 5; i++) begin
            wr_op(ro_codes[i], 1'b0, 1'b0, 16'hFFFF, 1'b1);
        end
        rd_chk(CMD_CAPABILITY, 1'b0, 16'h00B0);
        rd_chk(CMD_MAKER_ID, 1'b0, ID_VAL);
        i_host.xfer(1'b1, 8'h00, 1'b0, 1'b0, 16'h0000, v, n, q);
        chk({14'h0000, v, n}, 16'h0001, "unknown read");
    endtask

    task automatic s_info();
        rd_chk(CMD_MAKER_INFO, 1'b0, 16'h0020);
        refresh(1'b0);
        rd_chk(CMD_MAKER_INFO, 1'b0, 16'h0000);
        @(posedge sys_clk);
        ecc_clean <= 1'b1;
        rd_chk(CMD_MAKER_INFO, 1'b0, 16'h0000);
        refresh(1'b1);
        rd_chk(CMD_MAKER_INFO, 1'b0, 16'h0020);
    endtask

    task automatic s_scratch();
        rd_chk(CMD_SCRATCH_PG, 1'b0, 16'h0000);
        rd_chk(CMD_SCRATCH_PG, 1'b1, 16'h0000);
        rd_chk(CMD_SCRATCH_UNPG, 1'b1, 16'h0000);
        wr_op(CMD_SCRATCH_PG, 1'b0, 1'b0, 16'h1234, 1'b0);
        wr_op(CMD_SCRATCH_PG, 1'b1, 1'b0, 16'hABCD, 1'b0);
        wr_op(CMD_SCRATCH_UNPG, 1'b0, 1'b0, 16'hFEDC, 1'b0);
        rd_chk(CMD_SCRATCH_PG, 1'b0, 16'h1234);
        rd_chk(CMD_SCRATCH_PG, 1'b1, 16'hABCD);
        rd_chk(CMD_SCRATCH_UNPG, 1'b1, 16'hFEDC);
        wr_op(CMD_SCRATCH_PG, 1'b0, 1'b1, 16'h0F0F, 1'b0);
        rd_chk(CMD_SCRATCH_PG, 1'b1, 16'h0F0F);
        fork
            ee_put(CMD_SCRATCH_UNPG, 1'b0, 16'hAAAA);
            wr_op(CMD_SCRATCH_UNPG, 1'b0, 1'b0, 16'h5555, 1'b0);
        join
        rd_chk(CMD_SCRATCH_UNPG, 1'b0, 16'hAAAA);
    endtask

    task automatic s_tool();
        for (int i = 0; i < 4; i++) begin
            wr_op(rw_codes[i], 1'b0, 1'b0, {rw_codes[i], 8'h3C}, 1'b0);
            wr_op(rw_codes[i], 1'b1, 1'b0, {rw_codes[i], 8'hC3}, 1'b0);
        end
        rd_chk(CMD_TOOL_WORD_A, 1'b1, 16'hB0C3);
        rd_chk(CMD_TOOL_WORD_B_PG, 1'b0, 16'hB13C);
        rd_chk(CMD_TOOL_WORD_B_PG, 1'b1, 16'hB1C3);
        rd_chk(CMD_OEM_WORD, 1'b0, 16'hB2C3);
        rd_chk(CMD_MAKER_RSVD_PG, 1'b0, 16'hBC3C);
    endtask

    task automatic s_lot();
        ee_put(CMD_LOT_CODE, 1'b0, 16'h1234);
        ee_put(CMD_LOT_CODE, 1'b1, 16'h5678);
        rd_chk(CMD_LOT_CODE, 1'b0, 16'h0034);
        rd_chk(CMD_LOT_CODE, 1'b1, 16'h0078);
    endtask

    // mid-run reset: info word must recapture, scratch must clear
    task automatic s_reset();
        refresh(1'b0);
        wr_op(CMD_SCRATCH_PG, 1'b0, 1'b1, 16'h7E81, 1'b0);
        @(posedge sys_clk);
        ecc_clean <= 1'b1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_chk(CMD_MAKER_INFO, 1'b0, 16'h0020);
        rd_chk(CMD_SCRATCH_PG, 1'b1, 16'h0000);
    endtask

    // ==========================================================
    // verdict and main sequence
    // ==========================================================
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        $display("[ERR] %0t run did not finish", $time);
        final_report();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        s_info();
        s_ident();
        s_scratch();
        s_tool();
        s_lot();
        s_reset();
        final_report();
    end
endmodule // testbench
